// ==== rtl/ims_regs.vh ====
// Constants for the group-membership snooping filter.
// Included by the filter; definitions only.
`ifndef IMS_REGS_VH
`define IMS_REGS_VH

// Message type codes
`define IMS_TYPE_QUERY     8'h11
`define IMS_TYPE_REPORT_V2 8'h16
`define IMS_TYPE_LEAVE_V2  8'h17
`define IMS_TYPE_REPORT_V1 8'h12

// Field positions within the 64-bit message word
`define IMS_TYPE_LSB   0
`define IMS_TYPE_MSB   7
`define IMS_RTIME_LSB  8
`define IMS_RTIME_MSB  15
`define IMS_CSUM_LSB   16
`define IMS_CSUM_MSB   31
`define IMS_GROUP_LSB  32
`define IMS_GROUP_MSB  63

// Multicast range and query addressing
`define IMS_MCAST_PREFIX  4'he
`define IMS_ALL_HOSTS     32'he0000001
`define IMS_QUERY_TTL     8'h01
`define IMS_GROUP_ZERO    32'h00000000

// Query interval in microseconds and clock rate in MHz
`define IMS_QUERY_PERIOD_US 125000000
`define IMS_CLK_MHZ         200
`define IMS_QUERY_CYCLES    (`IMS_QUERY_PERIOD_US * 64'd`IMS_CLK_MHZ)

// Reset values
`define IMS_STAT_RESET 8'h00

`endif

// ==== rtl/ims_snoop_filter.v ====
// Group-membership snooping filter for a switch: parses messages,
// keeps member ports per group and VLAN, filters multicast egress.
// Assumes one core clock; message and frame inputs are one-cycle strobes.
//
// Function
// - Copy every group message to management processor
// - Forward multicast only to recorded member ports
// - Type 0x11, zero group: general query
// - Type 0x11, nonzero group: group-specific query
// - Type 0x16: version-2 report adds port
// - Type 0x17: version-2 leave for group
// - Type 0x12: version-1 report adds port
// - Type, response time, checksum, group word layout
// - Version-1 messages are fixed length
// - General queries sent to all-hosts address 224.0.0.1; group queries to the group address
// - Queries sent with time-to-live of one
// - Unanswered group query drops the leaving port only
// - Snooping enable switches whole function
// - Querier enable gates periodic queries; status
// - Quick leave drops port at once
// - 224.0.0.0 to 239.255.255.255 is multicast
`timescale 1ns/1ps
`include "ims_regs.vh"
module ims_snoop_filter #(
  parameter PORTS        = 8,
  parameter ENTRIES      = 16,
  parameter IDX_W        = 4,
  parameter PW           = 3,
  parameter QUERY_CYCLES = `IMS_QUERY_CYCLES,
  parameter RESP_CYCLES  = 2000000000
) (
  input  wire              ref_clk_i,
  input  wire              rst_i,
  input  wire              snoop_enable_i,
  input  wire              quick_leave_enable_i,
  input  wire              query_originate_enable_i,
  input  wire              msg_valid_i,
  input  wire [63:0]       msg_data_i,
  input  wire [11:0]       msg_vlan_i,
  input  wire [PW-1:0]     msg_port_i,
  input  wire              frm_valid_i,
  input  wire [31:0]       frm_dst_ip_i,
  input  wire [11:0]       frm_vlan_i,
  input  wire [PW-1:0]     frm_port_i,
  output reg               cpu_copy_o,
  output reg  [63:0]       cpu_msg_o,
  output reg  [11:0]       cpu_vlan_o,
  output reg  [PW-1:0]     cpu_port_o,
  output reg  [2:0]        cpu_kind_o,
  output reg               fwd_valid_o,
  output wire [PORTS-1:0]  fwd_mask_o,
  output reg               qry_send_o,
  output reg  [31:0]       qry_dst_ip_o,
  output reg  [31:0]       qry_group_o,
  output reg  [7:0]        qry_ttl_o,
  output reg  [7:0]        qry_status_o,
  output reg               grp_expired_o,
  output wire              table_full_o
);

  // ----------------------------------------
  // Message classification
  // ----------------------------------------
  localparam K_NONE  = 3'd0;
  localparam K_GQRY  = 3'd1;
  localparam K_SQRY  = 3'd2;
  localparam K_REP2  = 3'd3;
  localparam K_LEAVE = 3'd4;
  localparam K_REP1  = 3'd5;

  // Field extraction; fixed-length words, no trailing data
  wire [7:0]  m_type  = msg_data_i[`IMS_TYPE_MSB:`IMS_TYPE_LSB];
  wire [31:0] m_group = msg_data_i[`IMS_GROUP_MSB:`IMS_GROUP_LSB];
  wire        m_zero  = (m_group == `IMS_GROUP_ZERO);
  wire        m_mc    = (m_group[31:28] == `IMS_MCAST_PREFIX);

  reg [2:0] kind;
  always @* begin
    case (m_type)
      `IMS_TYPE_QUERY:     kind = m_zero ? K_GQRY : K_SQRY;
      `IMS_TYPE_REPORT_V2: kind = K_REP2;
      `IMS_TYPE_LEAVE_V2:  kind = K_LEAVE;
      `IMS_TYPE_REPORT_V1: kind = K_REP1;
      default:             kind = K_NONE;
    endcase
  end

  wire msg_take = msg_valid_i && snoop_enable_i && kind != K_NONE;

  // Copy to management processor
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      cpu_copy_o <= 1'b0;
      cpu_msg_o  <= 64'h0000000000000000;
      cpu_vlan_o <= 12'h000;
      cpu_port_o <= {PW{1'b0}};
      cpu_kind_o <= K_NONE;
    end else begin
      cpu_copy_o <= msg_take;
      if (msg_take) begin
        cpu_msg_o  <= msg_data_i;
        cpu_vlan_o <= msg_vlan_i;
        cpu_port_o <= msg_port_i;
        cpu_kind_o <= kind;
      end
    end
  end

  // ----------------------------------------
  // Table update selection
  // ----------------------------------------
  wire [PORTS-1:0] port_bit = {{(PORTS-1){1'b0}}, 1'b1} << msg_port_i;
  wire is_join  = (kind == K_REP2 || kind == K_REP1) && m_mc;
  wire is_leave = (kind == K_LEAVE) && m_mc;

  // Pending group query after a slow leave
  reg              pend_reg;
  reg [31:0]       pend_group_reg;
  reg [11:0]       pend_vlan_reg;
  reg [PORTS-1:0]  pend_port_reg;
  reg [31:0]       resp_cnt_reg;

  wire resp_done = pend_reg && (resp_cnt_reg == 32'h00000000);
  // A port drop waits while a message owns the table update
  wire resp_go   = resp_done
                   && !(msg_take && (is_join || (is_leave && quick_leave_enable_i)));
  wire pend_answer = msg_take && is_join && pend_reg
                     && m_group == pend_group_reg && msg_vlan_i == pend_vlan_reg;

  reg              upd;
  reg              upd_add;
  reg [31:0]       upd_group;
  reg [11:0]       upd_vlan;
  reg [PORTS-1:0]  upd_ports;
  always @* begin
    upd       = 1'b0;
    upd_add   = 1'b0;
    upd_group = m_group;
    upd_vlan  = msg_vlan_i;
    upd_ports = port_bit;
    if (msg_take && is_join) begin
      upd     = 1'b1;
      upd_add = 1'b1;
    end else if (msg_take && is_leave && quick_leave_enable_i) begin
      upd = 1'b1;
    end else if (resp_go) begin
      upd       = 1'b1;
      upd_group = pend_group_reg;
      upd_vlan  = pend_vlan_reg;
      upd_ports = pend_port_reg;
    end
  end

  // ----------------------------------------
  // Forwarding table and egress mask
  // ----------------------------------------
  wire [PORTS-1:0] lk_mask;
  ims_table #(
    .ENTRIES (ENTRIES),
    .PORTS   (PORTS),
    .IDX_W   (IDX_W)
  ) u_table (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .flush_i     (~snoop_enable_i),
    .upd_i       (upd),
    .upd_add_i   (upd_add),
    .upd_group_i (upd_group),
    .upd_vlan_i  (upd_vlan),
    .upd_ports_i (upd_ports),
    .lk_group_i  (frm_dst_ip_i),
    .lk_vlan_i   (frm_vlan_i),
    .lk_mask_o   (lk_mask),
    .lk_hit_o    (),
    .full_o      (table_full_o),
    .used_o      ()
  );

  // Frame context delayed to match table latency; the snoop decision
  // travels with the frame so a later toggle cannot alter its mask
  reg             frm_filt_reg;
  reg [PW-1:0]    frm_port_reg;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      fwd_valid_o  <= 1'b0;
      frm_filt_reg <= 1'b0;
      frm_port_reg <= {PW{1'b0}};
    end else begin
      fwd_valid_o  <= frm_valid_i;
      frm_filt_reg <= snoop_enable_i && (frm_dst_ip_i[31:28] == `IMS_MCAST_PREFIX);
      frm_port_reg <= frm_port_i;
    end
  end

  // Members only for multicast when snooping; flood otherwise; never back to source
  wire [PORTS-1:0] src_bit = {{(PORTS-1){1'b0}}, 1'b1} << frm_port_reg;
  wire [PORTS-1:0] raw_mask = frm_filt_reg ? lk_mask
                              : {PORTS{1'b1}};
  assign fwd_mask_o = fwd_valid_o ? (raw_mask & ~src_bit) : {PORTS{1'b0}};

  // ----------------------------------------
  // Querier: periodic timer and pending group query
  // ----------------------------------------
  // Reload values sized to the counters they load
  localparam [63:0] QC_LOAD = QUERY_CYCLES - 1;
  localparam [31:0] RC_LOAD = RESP_CYCLES - 1;

  reg [63:0] tick_reg;
  wire q_on   = snoop_enable_i && query_originate_enable_i;
  wire q_tick = q_on && tick_reg == 64'h0000000000000000;

  always @(posedge ref_clk_i) begin
    if (rst_i || !q_on)
      tick_reg <= QC_LOAD;
    else if (q_tick)
      tick_reg <= QC_LOAD;
    else
      tick_reg <= tick_reg - 64'h0000000000000001;
  end

  // Slow leave: send group query, drop port if unanswered
  wire start_pend = msg_take && is_leave && !quick_leave_enable_i && q_on && !pend_reg;
  always @(posedge ref_clk_i) begin
    if (rst_i || !snoop_enable_i) begin
      pend_reg       <= 1'b0;
      pend_group_reg <= 32'h00000000;
      pend_vlan_reg  <= 12'h000;
      pend_port_reg  <= {PORTS{1'b0}};
      resp_cnt_reg   <= 32'h00000000;
    end else if (start_pend) begin
      pend_reg       <= 1'b1;
      pend_group_reg <= m_group;
      pend_vlan_reg  <= msg_vlan_i;
      pend_port_reg  <= port_bit;
      resp_cnt_reg   <= RC_LOAD;
    end else if (pend_answer) begin
      pend_reg <= 1'b0;
    end else if (resp_done) begin
      if (resp_go)
        pend_reg <= 1'b0;
    end else if (pend_reg) begin
      resp_cnt_reg <= resp_cnt_reg - 32'h00000001;
    end
  end

  // Group query held one cycle when the periodic query takes the slot
  reg         gq_hold_reg;
  reg [31:0]  gq_group_reg;
  wire        gq_now  = q_on && ((start_pend && !q_tick) || gq_hold_reg);
  wire [31:0] gq_addr = gq_hold_reg ? gq_group_reg : m_group;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      gq_hold_reg  <= 1'b0;
      gq_group_reg <= 32'h00000000;
    end else begin
      gq_hold_reg <= start_pend && q_tick;
      if (start_pend && q_tick)
        gq_group_reg <= m_group;
    end
  end

  // Outgoing query descriptor
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      qry_send_o   <= 1'b0;
      qry_dst_ip_o <= 32'h00000000;
      qry_group_o  <= 32'h00000000;
      qry_ttl_o    <= 8'h00;
    end else begin
      qry_send_o <= q_tick || gq_now;
      if (q_tick) begin
        qry_dst_ip_o <= `IMS_ALL_HOSTS;
        qry_group_o  <= `IMS_GROUP_ZERO;
        qry_ttl_o    <= `IMS_QUERY_TTL;
      end else if (gq_now) begin
        qry_dst_ip_o <= gq_addr;
        qry_group_o  <= gq_addr;
        qry_ttl_o    <= `IMS_QUERY_TTL;
      end
    end
  end

  // Query status: count sent queries, flag expired groups
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      qry_status_o  <= `IMS_STAT_RESET;
      grp_expired_o <= 1'b0;
    end else begin
      grp_expired_o <= resp_go;
      if (q_tick || gq_now)
        qry_status_o <= qry_status_o + 8'h01;
    end
  end

endmodule // ims_snoop_filter

// ==== rtl/ims_table.v ====
// Forwarding table: group address, VLAN and member-port mask per entry.
// Assumes one update request per cycle from the parent filter.
`timescale 1ns/1ps
module ims_table #(
  parameter ENTRIES = 16,
  parameter PORTS   = 8,
  parameter IDX_W   = 4
) (
  input  wire              ref_clk_i,
  input  wire              rst_i,
  input  wire              flush_i,
  input  wire              upd_i,
  input  wire              upd_add_i,
  input  wire [31:0]       upd_group_i,
  input  wire [11:0]       upd_vlan_i,
  input  wire [PORTS-1:0]  upd_ports_i,
  input  wire [31:0]       lk_group_i,
  input  wire [11:0]       lk_vlan_i,
  output reg  [PORTS-1:0]  lk_mask_o,
  output reg               lk_hit_o,
  output reg               full_o,
  output reg  [IDX_W:0]    used_o
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [31:0]      group_ip_reg       [0:ENTRIES-1];
  reg [11:0]      vlan_reg           [0:ENTRIES-1];
  reg [PORTS-1:0] group_port_mask_reg [0:ENTRIES-1];
  wire [ENTRIES-1:0] valid_w;
  wire [ENTRIES-1:0] upd_hit_w;
  wire [ENTRIES-1:0] lk_hit_w;

  // Per-entry match terms
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : g_ent
      assign valid_w[g]   = |group_port_mask_reg[g];
      assign upd_hit_w[g] = valid_w[g] && group_ip_reg[g] == upd_group_i
                            && vlan_reg[g] == upd_vlan_i;
      assign lk_hit_w[g]  = valid_w[g] && group_ip_reg[g] == lk_group_i
                            && vlan_reg[g] == lk_vlan_i;
    end
  endgenerate

  // Pick matching entry, else first free one
  reg [IDX_W-1:0] hit_idx;
  reg [IDX_W-1:0] free_idx;
  reg             any_hit;
  reg             any_free;
  reg [PORTS-1:0] lk_mask_next;
  reg [IDX_W:0]   cnt;
  integer i;
  always @* begin
    hit_idx      = {IDX_W{1'b0}};
    free_idx     = {IDX_W{1'b0}};
    any_hit      = 1'b0;
    any_free     = 1'b0;
    lk_mask_next = {PORTS{1'b0}};
    cnt          = {(IDX_W+1){1'b0}};
    for (i = ENTRIES - 1; i >= 0; i = i - 1) begin
      if (upd_hit_w[i]) begin
        hit_idx = i[IDX_W-1:0];
        any_hit = 1'b1;
      end
      if (!valid_w[i]) begin
        free_idx = i[IDX_W-1:0];
        any_free = 1'b1;
      end
      if (lk_hit_w[i])
        lk_mask_next = lk_mask_next | group_port_mask_reg[i];
      if (valid_w[i])
        cnt = cnt + 1'b1;
    end
  end

  // Entry updates; empty mask frees the entry
  integer k;
  always @(posedge ref_clk_i) begin
    if (rst_i || flush_i) begin
      for (k = 0; k < ENTRIES; k = k + 1) begin
        group_ip_reg[k]        <= 32'h00000000;
        vlan_reg[k]            <= 12'h000;
        group_port_mask_reg[k] <= {PORTS{1'b0}};
      end
    end else if (upd_i) begin
      if (any_hit) begin
        if (upd_add_i)
          group_port_mask_reg[hit_idx] <= group_port_mask_reg[hit_idx] | upd_ports_i;
        else
          group_port_mask_reg[hit_idx] <= group_port_mask_reg[hit_idx] & ~upd_ports_i;
      end else if (upd_add_i && any_free) begin
        group_ip_reg[free_idx]        <= upd_group_i;
        vlan_reg[free_idx]            <= upd_vlan_i;
        group_port_mask_reg[free_idx] <= upd_ports_i;
      end
    end
  end

  // Registered lookup result and fill state
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      lk_mask_o <= {PORTS{1'b0}};
      lk_hit_o  <= 1'b0;
      full_o    <= 1'b0;
      used_o    <= {(IDX_W+1){1'b0}};
    end else begin
      lk_mask_o <= lk_mask_next;
      lk_hit_o  <= |lk_hit_w;
      full_o    <= ~any_free;
      used_o    <= cnt;
    end
  end

endmodule // ims_table

// ==== test/ims_host_model.sv ====
// Model of hosts and routers on the switch ports.
// Driven by task calls from tb; changes lines at the falling edge.
`timescale 1ns/1ps
module ims_host_model #(
  parameter PW = 3
) (
  input  wire          ref_clk_i,
  output reg           msg_valid_o,
  output reg  [63:0]   msg_data_o,
  output reg  [11:0]   msg_vlan_o,
  output reg  [PW-1:0] msg_port_o,
  output reg           frm_valid_o,
  output reg  [31:0]   frm_dst_ip_o,
  output reg  [11:0]   frm_vlan_o,
  output reg  [PW-1:0] frm_port_o
);
  // ----------------------------
  // Idle state at time zero
  // ----------------------------
  initial begin
    {msg_valid_o, msg_data_o, msg_vlan_o, msg_port_o} = '0;
    {frm_valid_o, frm_dst_ip_o, frm_vlan_o, frm_port_o} = '0;
  end

  // One message word; a join, leave or query as hosts send them
  task send_msg(input [7:0] t, input [31:0] g, input [11:0] v, input [PW-1:0] p);
    @(negedge ref_clk_i);
    msg_valid_o = 1'b1;
    msg_data_o  = {g, 16'h5a5a, 8'h64, t};
    msg_vlan_o  = v;
    msg_port_o  = p;
    @(negedge ref_clk_i);
    msg_valid_o = 1'b0;
    msg_data_o  = ~msg_data_o; // Stale word must not look valid
  endtask

  // One multicast or unicast data frame
  task send_frm(input [31:0] ip, input [11:0] v, input [PW-1:0] p);
    @(negedge ref_clk_i);
    frm_valid_o  = 1'b1;
    frm_dst_ip_o = ip;
    frm_vlan_o   = v;
    frm_port_o   = p;
    @(negedge ref_clk_i);
    frm_valid_o  = 1'b0;
    frm_dst_ip_o = ~frm_dst_ip_o;
  endtask
endmodule // ims_host_model

// ==== test/ims_snoop_filter_asserts.sv ====
// Checker for the snooping filter, on its top ports only.
// Bound to every ims_snoop_filter instance at the foot.
`timescale 1ns/1ps
module ims_snoop_chk #(
  parameter PORTS = 8,
  parameter PW    = 3
) (
  input wire             ref_clk_i,
  input wire             rst_i,
  input wire             snoop_enable_i,
  input wire             quick_leave_enable_i,
  input wire             query_originate_enable_i,
  input wire             msg_valid_i,
  input wire [63:0]      msg_data_i,
  input wire             frm_valid_i,
  input wire [PW-1:0]    frm_port_i,
  input wire             cpu_copy_o,
  input wire [2:0]       cpu_kind_o,
  input wire             fwd_valid_o,
  input wire [PORTS-1:0] fwd_mask_o,
  input wire             qry_send_o,
  input wire [31:0]      qry_dst_ip_o,
  input wire [31:0]      qry_group_o,
  input wire [7:0]       qry_ttl_o
);
  // ----------------------------
  // Decode helpers
  // ----------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire [7:0]       typ   = msg_data_i[7:0];
  wire             tk    = msg_valid_i && snoop_enable_i;
  wire             grp0  = (msg_data_i[63:32] == 32'h00000000);
  wire [PORTS-1:0] one   = {{(PORTS-1){1'b0}}, 1'b1};
  wire             grp0_q = (qry_group_o == 32'h00000000);

  // ----------------------------
  // Properties
  // ----------------------------
  chk_copy_taken: assert property (tk && (typ == 8'h11 || typ == 8'h16 ||
    typ == 8'h17 || typ == 8'h12) |=> cpu_copy_o) else $error("copy missing");
  chk_copy_cause: assert property (cpu_copy_o |-> $past(tk))
    else $error("copy without message");
  chk_gen_query: assert property (tk && typ == 8'h11 && grp0 |=> cpu_kind_o == 3'h1)
    else $error("general query kind");
  chk_grp_query: assert property (tk && typ == 8'h11 && !grp0 |=> cpu_kind_o == 3'h2)
    else $error("group query kind");
  chk_join_two: assert property (tk && typ == 8'h16 |=> cpu_kind_o == 3'h3)
    else $error("v2 report kind");
  chk_leave_kind: assert property (tk && typ == 8'h17 |=> cpu_kind_o == 3'h4)
    else $error("leave kind");
  chk_join_one: assert property (tk && typ == 8'h12 |=> cpu_kind_o == 3'h5)
    else $error("v1 report kind");
  chk_fwd_answer: assert property (frm_valid_i |=> fwd_valid_o ##0
    !fwd_mask_o[$past(frm_port_i)]) else $error("forward answer");
  chk_flood_off: assert property (frm_valid_i && !snoop_enable_i |=>
    fwd_mask_o == ~(one << $past(frm_port_i))) else $error("flood mask");
  chk_qry_addr: assert property (qry_send_o |-> qry_ttl_o == 8'h01 &&
    qry_dst_ip_o == (grp0_q ? 32'he0000001 : qry_group_o)) else $error("query address");
  chk_qry_gate: assert property (qry_send_o |-> $past(query_originate_enable_i))
    else $error("query while disabled");
  chk_quick_noq: assert property (tk && quick_leave_enable_i && typ == 8'h17
    |=> !(qry_send_o && qry_group_o != 32'h00000000)) else $error("query on quick leave");

  // Main scenarios reached
  cover property (cpu_copy_o);
  cover property (fwd_valid_o && fwd_mask_o != '0);
  cover property (qry_send_o);
endmodule // ims_snoop_chk

bind ims_snoop_filter ims_snoop_chk #(.PORTS(PORTS), .PW(PW)) u_chk (
  .ref_clk_i, .rst_i, .snoop_enable_i, .quick_leave_enable_i,
  .query_originate_enable_i, .msg_valid_i, .msg_data_i, .frm_valid_i,
  .frm_port_i, .cpu_copy_o, .cpu_kind_o, .fwd_valid_o, .fwd_mask_o,
  .qry_send_o, .qry_dst_ip_o, .qry_group_o, .qry_ttl_o);

// ==== test/tb.sv ====
// Self-checking bench for the snooping filter.
// Host model drives messages and frames; short query counts.
`timescale 1ns/1ps
module tb;
  localparam QC = 100;
  localparam RC = 50;
  localparam [31:0] G = 32'hef010101;
  reg         ref_clk_i, rst_i, snoop_enable_i;
  reg         quick_leave_enable_i, query_originate_enable_i;
  wire        msg_valid_i, frm_valid_i;
  wire [63:0] msg_data_i, cpu_msg_o;
  wire [11:0] msg_vlan_i, frm_vlan_i, cpu_vlan_o;
  wire [2:0]  msg_port_i, frm_port_i, cpu_port_o, cpu_kind_o;
  wire [31:0] frm_dst_ip_i, qry_dst_ip_o, qry_group_o;
  wire [7:0]  fwd_mask_o, qry_ttl_o, qry_status_o;
  wire        cpu_copy_o, fwd_valid_o, qry_send_o, grp_expired_o, table_full_o;
  integer     failures, n_tests, i;

  // ----------------------------
  // Clock, design and far side
  // ----------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  ims_snoop_filter #(.QUERY_CYCLES(QC), .RESP_CYCLES(RC)) u_dut (
    .ref_clk_i, .rst_i, .snoop_enable_i, .quick_leave_enable_i,
    .query_originate_enable_i, .msg_valid_i, .msg_data_i, .msg_vlan_i,
    .msg_port_i, .frm_valid_i, .frm_dst_ip_i, .frm_vlan_i, .frm_port_i,
    .cpu_copy_o, .cpu_msg_o, .cpu_vlan_o, .cpu_port_o, .cpu_kind_o,
    .fwd_valid_o, .fwd_mask_o, .qry_send_o, .qry_dst_ip_o, .qry_group_o,
    .qry_ttl_o, .qry_status_o, .grp_expired_o, .table_full_o);
  ims_host_model #(.PW(3)) u_host (
    .ref_clk_i, .msg_valid_o(msg_valid_i), .msg_data_o(msg_data_i),
    .msg_vlan_o(msg_vlan_i), .msg_port_o(msg_port_i), .frm_valid_o(frm_valid_i),
    .frm_dst_ip_o(frm_dst_ip_i), .frm_vlan_o(frm_vlan_i), .frm_port_o(frm_port_i));

  // ----------------------------
  // Shared tasks
  // ----------------------------
  task test_done;
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input [63:0] exp, input [63:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Kind 0 means the message must not be copied
  task msg_chk(input [7:0] t, input [31:0] g, input [2:0] p, input [2:0] kind);
    u_host.send_msg(t, g, 12'h001, p);
    chk("cpu_copy", kind != 3'h0, cpu_copy_o);
    if (kind != 3'h0) begin
      chk("cpu_kind", kind, cpu_kind_o);
      chk("cpu_msg", {g, 16'h5a5a, 8'h64, t}, cpu_msg_o);
      chk("cpu_vlan", 12'h001, cpu_vlan_o);
      chk("cpu_port", p, cpu_port_o);
    end
  endtask
  task frm_chk(input [31:0] ip, input [11:0] v, input [2:0] p, input [7:0] m);
    u_host.send_frm(ip, v, p);
    chk("fwd_valid", 1, fwd_valid_o);
    chk("fwd_mask", m, fwd_mask_o);
  endtask
  // Bounded wait for a query toward group g
  task wait_qry(input [31:0] g, input integer lim);
    for (i = 0; i < lim && !(qry_send_o === 1'b1 && qry_group_o === g); i = i + 1)
      @(negedge ref_clk_i);
    if (i == lim) begin
      failures = failures + 1;
      $display("Error qry_send expected 1 seen 0");
      test_done;
    end else begin
      chk("qry_dst", (g == 0) ? 32'he0000001 : g, qry_dst_ip_o);
      chk("qry_ttl", 8'h01, qry_ttl_o);
    end
  endtask

  // ----------------------------
  // Scenarios
  // ----------------------------
  task t_kinds;
    msg_chk(8'h11, 32'h00000000, 3'd1, 3'h1);
    msg_chk(8'h11, 32'he1020304, 3'd1, 3'h2);
    msg_chk(8'h17, 32'he1020304, 3'd1, 3'h4);
    msg_chk(8'h22, 32'he1020304, 3'd1, 3'h0);
  endtask
  task t_join;
    msg_chk(8'h16, G, 3'd2, 3'h3);
    msg_chk(8'h12, G, 3'd5, 3'h5);
    frm_chk(G, 12'h001, 3'd0, 8'h24);
    frm_chk(G, 12'h001, 3'd2, 8'h20);
    frm_chk(G, 12'h002, 3'd0, 8'h00);
    frm_chk(32'hefffffff, 12'h001, 3'd0, 8'h00);
    frm_chk(32'hf0000001, 12'h001, 3'd0, 8'hfe);
    frm_chk(32'h0a000001, 12'h001, 3'd1, 8'hfd);
  endtask
  task t_quick;
    quick_leave_enable_i = 1'b1;
    msg_chk(8'h17, G, 3'd2, 3'h4);
    frm_chk(G, 12'h001, 3'd0, 8'h20);
    quick_leave_enable_i = 1'b0;
  endtask
  task t_slow;
    query_originate_enable_i = 1'b1;
    msg_chk(8'h17, G, 3'd5, 3'h4);
    wait_qry(G, 3);
    for (i = 0; i < RC + 10 && grp_expired_o !== 1'b1; i = i + 1)
      @(negedge ref_clk_i);
    chk("grp_expired", 1, grp_expired_o);
    frm_chk(G, 12'h001, 3'd0, 8'h00);
  endtask
  task t_querier;
    wait_qry(32'h00000000, 2 * QC + 10);
    chk("qry_status", 8'h02, qry_status_o);
    query_originate_enable_i = 1'b0;
    @(negedge ref_clk_i);
    for (i = 0; i < 2 * QC + 10; i = i + 1) begin
      @(negedge ref_clk_i);
      chk("qry_send", 0, qry_send_o);
    end
  endtask
  // Fill every entry, then a new group must be dropped
  task t_full;
    for (i = 0; i < 16; i = i + 1)
      msg_chk(8'h16, 32'he0000100 + i, 3'd1, 3'h3);
    @(negedge ref_clk_i);
    chk("table_full", 1, table_full_o);
    msg_chk(8'h16, 32'he0000110, 3'd1, 3'h3);
    frm_chk(32'he0000110, 12'h001, 3'd0, 8'h00);
    frm_chk(32'he000010f, 12'h001, 3'd0, 8'h02);
  endtask
  task t_snoop_off;
    msg_chk(8'h16, G, 3'd3, 3'h3);
    snoop_enable_i = 1'b0;
    msg_chk(8'h16, G, 3'd4, 3'h0);
    frm_chk(G, 12'h001, 3'd0, 8'hfe);
    snoop_enable_i = 1'b1;
    frm_chk(G, 12'h001, 3'd0, 8'h00);
    chk("table_full", 0, table_full_o);
  endtask

  // Reset, then every scenario in turn
  initial begin
    failures = 0;
    n_tests = 0;
    rst_i = 1'b1;
    snoop_enable_i = 1'b1;
    quick_leave_enable_i = 1'b0;
    query_originate_enable_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_kinds;
    t_join;
    t_quick;
    t_slow;
    t_querier;
    t_full;
    t_snoop_off;
    test_done;
  end
endmodule // tb
